//--- logic/uart_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the serial transceiver. Assumes an 8-register byte-wide space.
 */
// Functional notes
// - Ring indicator pin rising from low to high raises a modem-status event.
// - Modem control bit 1 set drives request-to-send output low.
// - Request-to-send output is high after reset.
// - Request-to-send follows receive fill level only with enhanced bit 6.
// - Modem control bit 6 picks standard line or infrared codec path.
// - Receive line idles high in standard mode, low in infrared mode.
// - Serial output idles high in standard mode, low in infrared mode.
// - Loopback ignores the serial input pin and feeds transmit into receiver.
// - Transmitter sends start bit, data, optional parity and stop bits.
// - Receiver rebuilds words and flags parity mismatch as an error.
// - Transmit and receive characters are held in two 16-byte FIFOs.
// - Four software-selected receive fill levels raise the trigger event.
// - Divisor bytes are mapped only while line control bit 7 is set.
// - Enhanced and flow character registers appear only while line control is bf.
// - Offset zero reads receive holding and writes transmit holding.
// - After reset the register model is legacy, enhanced features off.
// - Divisor of one gives 1.5 Mb/s from a 24 MHz clock.
// - Prescale option divides by four, giving 115.2 kb/s from 7.3728 MHz.
// - Baud generator emits a sixteen-times enable, also clocking the receiver.
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH
`define OFS_HOLD      3'h0
`define OFS_IER       3'h1
`define OFS_ISR       3'h2
`define OFS_LCR       3'h3
`define OFS_MCR       3'h4
`define OFS_LSR       3'h5
`define OFS_MSR       3'h6
`define OFS_SPR       3'h7
`define ENH_KEY       8'hbf
`define LCR_DLAB      7
`define LCR_BREAK     6
`define MCR_RTS       1
`define MCR_LOOP      4
`define MCR_IR        6
`define MCR_PRESCALE  7
`define EFR_AUTO_RTS  6
`define EFR_AUTO_CTS  7
`define REG_RESET     8'h00
`define TRIG_LVL0     5'h01
`define TRIG_LVL1     5'h04
`define TRIG_LVL2     5'h08
`define TRIG_LVL3     5'h0e
`define OVERSAMPLE    4'hf
`define MID_SAMPLE    4'h7
`define IR_PULSE      4'h3
`define IR_HOLD       5'h10
`define PRESCALE_MAX  2'h3
`define ISR_NONE      8'h01
`define ISR_LINE      8'h06
`define ISR_RXDATA    8'h04
`define ISR_THRE      8'h02
`define ISR_MODEM     8'h00
`endif

//--- logic/uart_pkg.sv
/*
 * Types shared by the transceiver files.
 * Assumes uart_defs.svh supplies the numeric constants.
 */
package uart_pkg;
  // Gray coded along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    FS_IDLE   = 3'b000,
    FS_START  = 3'b001,
    FS_DATA   = 3'b011,
    FS_PARITY = 3'b010,
    FS_STOP   = 3'b110
  } frame_state_e;
  typedef struct packed {
    logic [1:0] word_len;
    logic       two_stop;
    logic       par_en;
    logic       par_even;
    logic       par_stick;
  } line_cfg_s;
  typedef struct packed {
    logic       frm_err;
    logic       par_err;
    logic [7:0] data;
  } rx_char_s;
endpackage

//--- logic/char_fifo.sv
/*
 * Character FIFO with valid/ready on both sides and a fill level.
 * Assumes one clock and a synchronous active-low reset.
 */
module char_fifo #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          clear_i,
  // Fill side
  input  wire logic          wr_valid_i,
  output logic               wr_ready_o,
  input  wire logic [W-1:0]  wr_data_i,
  // Drain side
  output logic               rd_valid_o,
  input  wire logic          rd_ready_i,
  output logic [W-1:0]       rd_data_o,
  output logic [AW:0]        level_o
);
  logic [W-1:0] mem_ff [2**AW];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  wire           push_w = wr_valid_i & wr_ready_o;
  wire           pop_w  = rd_valid_o & rd_ready_i;
  assign wr_ready_o = cnt_ff != (AW+1)'(2**AW);
  assign rd_valid_o = cnt_ff != '0;
  assign rd_data_o  = mem_ff[rp_ff];
  assign level_o    = cnt_ff;
  always_ff @(posedge ref_clk_i)
  begin
    if (push_w)
      mem_ff[wp_ff] <= wr_data_i;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i || clear_i)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff  <= wp_ff + AW'(push_w);
      rp_ff  <= rp_ff + AW'(pop_w);
      cnt_ff <= cnt_ff + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
endmodule

//--- logic/uart_rx.sv
/*
 * Receiver: oversamples the line on the sixteen-times enable.
 * Assumes the line input is already synchronous to ref_clk_i.
 */
`include "uart_defs.svh"
module uart_rx (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_b_i,
  // Line side
  input  wire logic               tick16_i,
  input  wire logic               rxd_i,
  input  wire uart_pkg::line_cfg_s cfg_i,
  // Character out
  output logic                    valid_o,
  output uart_pkg::rx_char_s      char_o
);
  import uart_pkg::*;
  frame_state_e st_ff;
  logic [3:0]   sub_ff;
  logic [2:0]   bit_ff;
  logic [7:0]   sh_ff;
  logic         perr_ff;
  wire  [2:0]   last_w = 3'h4 + {1'b0, cfg_i.word_len};
  wire  [7:0]   data_w = sh_ff >> (2'h3 - cfg_i.word_len);
  wire          exp_w  = cfg_i.par_stick ? ~cfg_i.par_even :
                         (cfg_i.par_even ? ^data_w : ~^data_w);
  wire          mid_w  = sub_ff == `OVERSAMPLE;
  always_ff @(posedge ref_clk_i)
  begin
    valid_o <= 1'b0;
    if (!rst_b_i)
    begin
      st_ff   <= FS_IDLE;
      sub_ff  <= '0;
      bit_ff  <= '0;
      sh_ff   <= '0;
      perr_ff <= 1'b0;
      char_o  <= '0;
    end
    else if (tick16_i)
    begin
      sub_ff <= sub_ff + 4'h1;
      case (st_ff)
        FS_IDLE:
        begin
          sub_ff  <= '0;
          perr_ff <= 1'b0;
          if (!rxd_i)
            st_ff <= FS_START;
        end
        FS_START:
          if (sub_ff == `MID_SAMPLE)
          begin
            sub_ff <= '0;
            bit_ff <= '0;
            st_ff  <= rxd_i ? FS_IDLE : FS_DATA;
          end
        FS_DATA:
          if (mid_w)
          begin
            sh_ff  <= {rxd_i, sh_ff[7:1]};
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == last_w)
              st_ff <= cfg_i.par_en ? FS_PARITY : FS_STOP;
          end
        FS_PARITY:
          if (mid_w)
          begin
            perr_ff <= rxd_i != exp_w;
            st_ff   <= FS_STOP;
          end
        FS_STOP:
          if (mid_w)
          begin
            valid_o <= 1'b1;
            char_o  <= '{frm_err: !rxd_i, par_err: perr_ff,
                         data: data_w};
            st_ff   <= FS_IDLE;
          end
        default:
          st_ff <= FS_IDLE;
      endcase
    end
  end
endmodule

//--- logic/uart_top.sv
/*
 * Serial transceiver: register decode, baud generator, transmitter,
 * infrared codec, loopback and modem lines.
 * Assumes a host doing single-cycle strobed accesses on ref_clk_i.
 */
// Local design decisions: strobed register access and the placing of the registers.
`include "uart_defs.svh"
module uart_top (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // Register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Serial line
  input  wire logic       serial_in_i,
  output logic            serial_out_o,
  // Modem lines
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       cd_n_i,
  input  wire logic       ring_indicator_n_i,
  output logic            rts_n_o,
  output logic            dtr_n_o,
  // Status
  output logic            baud16_o,
  output logic            int_o
);
  import uart_pkg::*;

  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [7:0] dll_ff;
  logic [7:0] dlm_ff;
  logic [7:0] ier_ff;
  logic [7:0] fcr_ff;
  logic [7:0] efr_ff;
  logic [7:0] lcr_ff;
  logic [7:0] mcr_ff;
  logic [7:0] spr_ff;
  logic [7:0] xon1_ff;
  logic [7:0] xon2_ff;
  logic [7:0] xoff1_ff;
  logic [7:0] xoff2_ff;
  logic [3:1] lerr_ff;
  logic [3:0] mdelta_ff;
  logic [3:0] mprev_ff;

  // ***********************************************************
  // Address decode
  // ***********************************************************
  wire dlab_w = lcr_ff[`LCR_DLAB];
  wire enh_w  = lcr_ff == `ENH_KEY;
  wire a0_w   = addr_i == `OFS_HOLD;
  wire a1_w   = addr_i == `OFS_IER;
  wire a2_w   = addr_i == `OFS_ISR;
  wire a3_w   = addr_i == `OFS_LCR;
  wire a4_w   = addr_i == `OFS_MCR;
  wire a5_w   = addr_i == `OFS_LSR;
  wire a6_w   = addr_i == `OFS_MSR;
  wire a7_w   = addr_i == `OFS_SPR;
  wire wr_thr_w  = wr_i & a0_w & !dlab_w;
  wire wr_dll_w  = wr_i & a0_w & dlab_w;
  wire wr_dlm_w  = wr_i & a1_w & dlab_w;
  wire wr_ier_w  = wr_i & a1_w & !dlab_w;
  wire wr_fcr_w  = wr_i & a2_w & !enh_w;
  wire wr_efr_w  = wr_i & a2_w & enh_w;
  wire wr_lcr_w  = wr_i & a3_w;
  wire wr_mcr_w  = wr_i & a4_w & !enh_w;
  wire wr_xon1_w = wr_i & a4_w & enh_w;
  wire wr_xon2_w = wr_i & a5_w & enh_w;
  wire wr_xof1_w = wr_i & a6_w & enh_w;
  wire wr_xof2_w = wr_i & a7_w & enh_w;
  wire wr_spr_w  = wr_i & a7_w & !enh_w;
  wire rd_rhr_w  = rd_i & a0_w & !dlab_w;
  wire rd_lsr_w  = rd_i & a5_w & !enh_w;
  wire rd_msr_w  = rd_i & a6_w & !enh_w;

  // ***********************************************************
  // Baud generator
  // ***********************************************************
  logic [1:0]  pre_ff;
  logic [15:0] bcnt_ff;
  wire  [15:0] div_w    = {dlm_ff, dll_ff};
  // Divide by four when the prescale bit is set
  wire         pre_en_w = !mcr_ff[`MCR_PRESCALE] ||
                          pre_ff == `PRESCALE_MAX;
  // Divisor one gives one enable per prescaled clock
  wire         tick16_w = pre_en_w && div_w != 16'h0000 &&
                          bcnt_ff >= div_w - 16'h0001;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      pre_ff  <= '0;
      bcnt_ff <= '0;
    end
    else
    begin
      pre_ff <= pre_ff + 2'h1;
      if (pre_en_w)
        bcnt_ff <= tick16_w ? 16'h0000 : bcnt_ff + 16'h0001;
    end
  end

  // ***********************************************************
  // FIFOs
  // ***********************************************************
  logic       tx_rdy_w;
  logic       tx_val_w;
  logic [7:0] tx_dat_w;
  logic [4:0] tx_lvl_w;
  logic       tx_pop_w;
  logic       rx_rdy_w;
  logic       rx_val_w;
  rx_char_s   rx_top_w;
  logic [4:0] rx_lvl_w;
  logic       rx_push_w;
  rx_char_s   rx_char_w;
  wire        clr_rx_w = wr_fcr_w & wdata_i[1];
  wire        clr_tx_w = wr_fcr_w & wdata_i[2];

  char_fifo #(.W(8), .AW(4)) u_tx_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .clear_i    (clr_tx_w),
    .wr_valid_i (wr_thr_w),
    .wr_ready_o (tx_rdy_w),
    .wr_data_i  (wdata_i),
    .rd_valid_o (tx_val_w),
    .rd_ready_i (tx_pop_w),
    .rd_data_o  (tx_dat_w),
    .level_o    (tx_lvl_w)
  );

  char_fifo #(.W(10), .AW(4)) u_rx_fifo (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .clear_i    (clr_rx_w),
    .wr_valid_i (rx_push_w),
    .wr_ready_o (rx_rdy_w),
    .wr_data_i  (rx_char_w),
    .rd_valid_o (rx_val_w),
    .rd_ready_i (rd_rhr_w),
    .rd_data_o  (rx_top_w),
    .level_o    (rx_lvl_w)
  );

  // ***********************************************************
  // Transmitter
  // ***********************************************************
  frame_state_e tx_st_ff;
  logic [3:0]   tx_sub_ff;
  logic [2:0]   tx_bit_ff;
  logic [7:0]   tx_sh_ff;
  logic         tx_par_ff;
  logic         tx_stop2_ff;
  logic         tx_line_ff;
  line_cfg_s    cfg_w;
  assign cfg_w = '{word_len: lcr_ff[1:0], two_stop: lcr_ff[2],
                   par_en: lcr_ff[3], par_even: lcr_ff[4],
                   par_stick: lcr_ff[5]};
  wire [2:0] tx_last_w = 3'h4 + {1'b0, cfg_w.word_len};
  wire [7:0] tx_msk_w  = tx_dat_w & (8'hff >> (2'h3 - cfg_w.word_len));
  wire       tx_pbit_w = cfg_w.par_stick ? ~cfg_w.par_even :
                         (cfg_w.par_even ? ^tx_msk_w : ~^tx_msk_w);
  // Auto CTS holds new characters while the far end is not ready
  wire       cts_hold_w = efr_ff[`EFR_AUTO_CTS] & cts_n_i;
  wire       tx_end_w   = tick16_w && tx_sub_ff == `OVERSAMPLE;
  wire       tx_idle_w  = tx_st_ff == FS_IDLE;
  assign tx_pop_w = tick16_w & tx_idle_w & tx_val_w & !cts_hold_w;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      tx_st_ff    <= FS_IDLE;
      tx_sub_ff   <= '0;
      tx_bit_ff   <= '0;
      tx_sh_ff    <= '0;
      tx_par_ff   <= 1'b0;
      tx_stop2_ff <= 1'b0;
      tx_line_ff  <= 1'b1;
    end
    else if (tick16_w)
    begin
      tx_sub_ff <= tx_sub_ff + 4'h1;
      case (tx_st_ff)
        FS_IDLE:
        begin
          tx_sub_ff  <= '0;
          tx_line_ff <= 1'b1;
          if (tx_pop_w)
          begin
            tx_sh_ff   <= tx_msk_w;
            tx_par_ff  <= tx_pbit_w;
            tx_line_ff <= 1'b0;
            tx_st_ff   <= FS_START;
          end
        end
        FS_START:
          if (tx_end_w)
          begin
            tx_bit_ff  <= '0;
            tx_line_ff <= tx_sh_ff[0];
            tx_sh_ff   <= tx_sh_ff >> 1;
            tx_st_ff   <= FS_DATA;
          end
        FS_DATA:
          if (tx_end_w)
          begin
            tx_bit_ff <= tx_bit_ff + 3'h1;
            tx_sh_ff  <= tx_sh_ff >> 1;
            tx_line_ff <= tx_sh_ff[0];
            if (tx_bit_ff == tx_last_w)
            begin
              tx_line_ff  <= cfg_w.par_en ? tx_par_ff : 1'b1;
              tx_stop2_ff <= cfg_w.two_stop;
              tx_st_ff    <= cfg_w.par_en ? FS_PARITY : FS_STOP;
            end
          end
        FS_PARITY:
          if (tx_end_w)
          begin
            tx_line_ff <= 1'b1;
            tx_st_ff   <= FS_STOP;
          end
        FS_STOP:
          if (tx_end_w)
          begin
            tx_stop2_ff <= 1'b0;
            if (!tx_stop2_ff)
              tx_st_ff <= FS_IDLE;
          end
        default:
          tx_st_ff <= FS_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // Line paths, infrared codec and loopback
  // ***********************************************************
  logic [4:0] ir_hold_ff;
  wire ir_w    = mcr_ff[`MCR_IR];
  wire loop_w  = mcr_ff[`MCR_LOOP];
  wire raw_w   = tx_line_ff & !lcr_ff[`LCR_BREAK];
  // Zero bits become a pulse in the first sixteenths of the bit
  wire ir_tx_w = !raw_w && tx_sub_ff < `IR_PULSE;
  // A received high pulse reads as zero for one bit time
  wire ir_rx_w = ir_hold_ff == 5'h00;
  wire ext_w   = ir_w ? ir_rx_w : serial_in_i;
  wire rxd_w   = loop_w ? raw_w : ext_w;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      ir_hold_ff <= '0;
    else if (ir_w && serial_in_i)
      ir_hold_ff <= `IR_HOLD;
    else if (tick16_w && ir_hold_ff != 5'h00)
      ir_hold_ff <= ir_hold_ff - 5'h01;
  end

  uart_rx u_rx (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .tick16_i  (tick16_w),
    .rxd_i     (rxd_w),
    .cfg_i     (cfg_w),
    .valid_o   (rx_push_w),
    .char_o    (rx_char_w)
  );

  // ***********************************************************
  // Status: line, modem, trigger and interrupt identity
  // ***********************************************************
  wire [4:0] trig_w = fcr_ff[7:6] == 2'h0 ? `TRIG_LVL0 :
                      fcr_ff[7:6] == 2'h1 ? `TRIG_LVL1 :
                      fcr_ff[7:6] == 2'h2 ? `TRIG_LVL2 :
                                            `TRIG_LVL3;
  wire       trig_hit_w = rx_lvl_w >= trig_w;
  wire [3:1] lerr_set_w = {rx_push_w & rx_char_w.frm_err,
                           rx_push_w & rx_char_w.par_err,
                           rx_push_w & !rx_rdy_w};
  wire       tx_empty_w = tx_lvl_w == 5'h00;
  wire [7:0] lsr_w = {1'b0, tx_empty_w & tx_idle_w, tx_empty_w,
                      1'b0, lerr_ff, rx_val_w};
  // Active levels: cd, ri, dsr, cts; loopback uses modem control
  wire [3:0] mact_w = loop_w ? {mcr_ff[3], mcr_ff[2], mcr_ff[0],
                                mcr_ff[1]} :
                      ~{cd_n_i, ring_indicator_n_i, dsr_n_i, cts_n_i};
  wire [3:0] mset_w = {mact_w[3] ^ mprev_ff[3],
                       mprev_ff[2] & !mact_w[2],
                       mact_w[1] ^ mprev_ff[1],
                       mact_w[0] ^ mprev_ff[0]};
  wire [7:0] msr_w  = {mact_w, mdelta_ff};
  wire [7:0] isr_id_w =
    (ier_ff[2] && lerr_ff != 3'h0)    ? `ISR_LINE   :
    (ier_ff[0] && trig_hit_w)         ? `ISR_RXDATA :
    (ier_ff[1] && tx_empty_w)         ? `ISR_THRE   :
    (ier_ff[3] && mdelta_ff != 4'h0)  ? `ISR_MODEM  :
                                        `ISR_NONE;
  wire [7:0] isr_w = isr_id_w | {fcr_ff[0], fcr_ff[0], 6'h00};
  wire [7:0] rd_mux_w =
    a0_w ? (dlab_w ? dll_ff : rx_top_w.data) :
    a1_w ? (dlab_w ? dlm_ff : ier_ff) :
    a2_w ? (enh_w ? efr_ff : isr_w) :
    a3_w ? lcr_ff :
    a4_w ? (enh_w ? xon1_ff : mcr_ff) :
    a5_w ? (enh_w ? xon2_ff : lsr_w) :
    a6_w ? (enh_w ? xoff1_ff : msr_w) :
           (enh_w ? xoff2_ff : spr_ff);
  // Request-to-send drops while the receive FIFO is at its level
  wire rts_act_w = mcr_ff[`MCR_RTS] &&
                   (!efr_ff[`EFR_AUTO_RTS] || !trig_hit_w);

  // ***********************************************************
  // Register storage
  // ***********************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      dll_ff   <= `REG_RESET;
      dlm_ff   <= `REG_RESET;
      ier_ff   <= `REG_RESET;
      fcr_ff   <= `REG_RESET;
      efr_ff   <= `REG_RESET;
      lcr_ff   <= `REG_RESET;
      mcr_ff   <= `REG_RESET;
      spr_ff   <= `REG_RESET;
      xon1_ff  <= `REG_RESET;
      xon2_ff  <= `REG_RESET;
      xoff1_ff <= `REG_RESET;
      xoff2_ff <= `REG_RESET;
    end
    else
    begin
      if (wr_dll_w)  dll_ff   <= wdata_i;
      if (wr_dlm_w)  dlm_ff   <= wdata_i;
      if (wr_ier_w)  ier_ff   <= wdata_i;
      if (wr_fcr_w)  fcr_ff   <= wdata_i;
      if (wr_efr_w)  efr_ff   <= wdata_i;
      if (wr_lcr_w)  lcr_ff   <= wdata_i;
      if (wr_mcr_w)  mcr_ff   <= wdata_i;
      if (wr_spr_w)  spr_ff   <= wdata_i;
      if (wr_xon1_w) xon1_ff  <= wdata_i;
      if (wr_xon2_w) xon2_ff  <= wdata_i;
      if (wr_xof1_w) xoff1_ff <= wdata_i;
      if (wr_xof2_w) xoff2_ff <= wdata_i;
    end
  end

  // Sticky flags: a new event wins over a clearing read
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      lerr_ff   <= '0;
      mdelta_ff <= '0;
      // Track the pins in reset so no false delta follows release
      mprev_ff  <= mact_w;
    end
    else
    begin
      lerr_ff   <= (rd_lsr_w ? 3'h0 : lerr_ff) | lerr_set_w;
      mdelta_ff <= (rd_msr_w ? 4'h0 : mdelta_ff) | mset_w;
      mprev_ff  <= mact_w;
    end
  end

  // ***********************************************************
  // Output flops
  // ***********************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o      <= 8'h00;
      serial_out_o <= 1'b1;
      rts_n_o      <= 1'b1;
      dtr_n_o      <= 1'b1;
      baud16_o     <= 1'b0;
      int_o        <= 1'b0;
    end
    else
    begin
      rdata_o      <= rd_i ? rd_mux_w : 8'h00;
      // Loopback parks the pin at the idle level of the chosen mode
      serial_out_o <= loop_w ? !ir_w :
                      (ir_w ? ir_tx_w : raw_w);
      rts_n_o      <= loop_w | !rts_act_w;
      dtr_n_o      <= loop_w | !mcr_ff[0];
      baud16_o     <= tick16_w;
      int_o        <= !isr_id_w[0];
    end
  end
endmodule

//--- verif/uart_props.sv
/* Checker of uart_top register decode and line levels.
   Assumes it is bound into uart_top. */
module uart_props (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  // Host and lines
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       serial_out_o,
  input wire logic       rts_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] lcr_ff, spr_ff, dll_ff, efr_ff;
  logic       bf;
  logic       mcr_w;
  assign bf = lcr_ff == 8'hbf;
  assign mcr_w = wr_i && addr_i == 3'h4 && !bf;
  // Shadow copies of writable registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      {lcr_ff, spr_ff, dll_ff, efr_ff} <= 32'h0;
    else if (wr_i)
    begin
      if (addr_i == 3'h3) lcr_ff <= wdata_i;
      if (addr_i == 3'h7 && !bf) spr_ff <= wdata_i;
      if (addr_i == 3'h0 && lcr_ff[7]) dll_ff <= wdata_i;
      if (addr_i == 3'h2 && bf) efr_ff <= wdata_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  rst_rts_a: assert property (!rst_b_i |=> rts_n_o)
    else $error("rts not high after reset");
  rst_line_a: assert property (!rst_b_i |=> serial_out_o)
    else $error("line not high after reset");
  rts_on_a: assert property (disable iff (!rst_b_i)
    mcr_w && wdata_i[1] && !wdata_i[4] && !efr_ff[6]
    |-> ##[1:2] !rts_n_o) else $error("rts not driven low");
  loop_rts_a: assert property (disable iff (!rst_b_i)
    mcr_w && wdata_i[4] |-> ##[1:2] rts_n_o)
    else $error("rts not forced high in loopback");
  spr_rd_a: assert property (disable iff (!rst_b_i)
    rd_i && addr_i == 3'h7 && !bf |=> rdata_o == spr_ff)
    else $error("scratchpad read mismatch");
  lcr_rd_a: assert property (disable iff (!rst_b_i)
    rd_i && addr_i == 3'h3 |=> rdata_o == lcr_ff)
    else $error("line control read mismatch");
  dll_rd_a: assert property (disable iff (!rst_b_i)
    rd_i && addr_i == 3'h0 && lcr_ff[7] |=> rdata_o == dll_ff)
    else $error("divisor low read mismatch");
  efr_rd_a: assert property (disable iff (!rst_b_i)
    rd_i && addr_i == 3'h2 && bf |=> rdata_o == efr_ff)
    else $error("enhanced feature read mismatch");
endmodule
bind uart_top uart_props chk (.*);

//--- verif/remote_peer.sv
/* Remote serial peer sending 8-bit even parity frames.
   Assumes BIT clocks per bit, as the device divisor gives. */
module remote_peer #(
  parameter int BIT = 32
) (
  // Clock
  input  wire logic ref_clk_i,
  // Line toward the device
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line_o = 1'b1;
  // Bad set flips the parity bit
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {1'b1, ^d ^ bad, d};
    @(posedge ref_clk_i) line_o <= 1'b0;
    repeat (BIT) @(posedge ref_clk_i);
    for (int i = 0; i < 10; i++)
    begin
      line_o <= f[i];
      repeat (BIT) @(posedge ref_clk_i);
    end
  endtask
endmodule

//--- verif/tb.sv
/* Bench of uart_top: register tasks, line and loopback tests.
   Assumes divisor 2, so one bit lasts 32 clocks. */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_b, wr, rd, sin, ri_n;
  logic       sout, rts_n, dtr_n, irq, b16;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  int         n_errors, compares, cyc, nb;
  uart_top dut (.ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .serial_in_i(sin), .serial_out_o(sout), .cts_n_i(1'b0),
    .dsr_n_i(1'b0), .cd_n_i(1'b0), .ring_indicator_n_i(ri_n),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .baud16_o(b16), .int_o(irq));
  remote_peer #(.BIT(32)) peer (.ref_clk_i(clk), .line_o(sin));
  task automatic chk(input string n, input logic [7:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic r(input string n, input logic [2:0] a,
                   input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic tx_chk(input logic [7:0] v);
    logic [9:0] f;
    int i;
    f = {1'b1, ^v, v};
    for (i = 0; i < 2000 && sout !== 1'b0; i++) @(posedge clk) #1;
    repeat (16) @(posedge clk);
    #1 chk("start", 8'h00, {7'h0, sout});
    for (i = 0; i < 10; i++)
    begin
      repeat (32) @(posedge clk);
      #1 chk("txbit", {7'h0, f[i]}, {7'h0, sout});
    end
  endtask
  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    {rst_b, wr, rd, addr, wdata, ri_n} = 15'h1;
    {n_errors, compares, cyc} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk("pins", 8'h07, {5'h0, rts_n, dtr_n, sout});
    r("lcr", 3'h3, 8'h00);
    w(3'h3, 8'h80);
    w(3'h0, 8'h02);
    w(3'h1, 8'h00);
    r("dll", 3'h0, 8'h02);
    w(3'h3, 8'hbf);
    w(3'h2, 8'h10);
    w(3'h4, 8'h11);
    r("efr", 3'h2, 8'h10);
    r("xon1", 3'h4, 8'h11);
    w(3'h3, 8'h1b);
    r("mcr", 3'h4, 8'h00);
    w(3'h7, 8'h5c);
    r("spr", 3'h7, 8'h5c);
    w(3'h4, 8'h03);
    repeat (2) @(posedge clk);
    #1 chk("rts_dtr", 8'h00, {6'h0, rts_n, dtr_n});
    nb = 0;
    repeat (32) @(posedge clk) #1 nb += b16;
    chk("baud16", 8'h10, 8'(nb));
    w(3'h4, 8'h83);
    nb = 0;
    repeat (32) @(posedge clk) #1 nb += b16;
    chk("prescale", 8'h04, 8'(nb));
    w(3'h4, 8'h00);
    w(3'h0, 8'ha5);
    tx_chk(8'ha5);
    peer.send(8'h5a, 1'b0);
    repeat (40) @(posedge clk);
    r("lsr", 3'h5, 8'h61);
    r("rhr", 3'h0, 8'h5a);
    peer.send(8'h33, 1'b1);
    repeat (40) @(posedge clk);
    r("lsr_par", 3'h5, 8'h65);
    r("rhr_par", 3'h0, 8'h33);
    w(3'h4, 8'h10);
    w(3'h0, 8'h3c);
    peer.send(8'h00, 1'b0);
    repeat (60) @(posedge clk);
    r("loop_rhr", 3'h0, 8'h3c);
    w(3'h4, 8'h40);
    repeat (4) @(posedge clk);
    #1 chk("ir_idle", 8'h00, {7'h0, sout});
    w(3'h4, 8'h00);
    r("msr0", 3'h6, 8'hbb);
    w(3'h1, 8'h08);
    repeat (3) @(posedge clk);
    #1 chk("no_int", 8'h00, {7'h0, irq});
    @(posedge clk) ri_n <= 1'b0;
    @(posedge clk) ri_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("ring_int", 8'h01, {7'h0, irq});
    r("msr", 3'h6, 8'hb4);
    results();
  end
endmodule
